// [include/jtag_tap_defs.vh]
// Constants for the memory test access port
`ifndef JTAG_TAP_DEFS_VH
`define JTAG_TAP_DEFS_VH
`define IR_WIDTH        3
`define IR_EXT_TEST     3'h0
`define IR_IDENT        3'h1
`define IR_SAMPLE_HIZ   3'h2
`define IR_SAMPLE_PRE   3'h4
`define IR_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1
`define ID_WIDTH        32
`define BSR_LEN         109
`define BSR_PINS        108
`define BSR_OE_BIT      108
`define ID_REV_MSB      31
`define ID_REV_LSB      29
`define ID_PART_MSB     28
`define ID_PART_LSB     12
`define ID_MAKER_MSB    11
`define ID_MAKER_LSB    1
`define ID_PRESENT_BIT  0
`define SYNC_STAGES     2
`endif

// [verilog/tap_state_ctrl.v]
// Test access port state controller driven by detected test clock edges
`timescale 1ns/10ps
`default_nettype none
module tap_state_ctrl (
  input  wire       clock_in,     // System clock
  input  wire       reset_n_in,   // Asynchronous reset, active low
  input  wire       tck_rise_in,  // Test clock rising edge pulse
  input  wire       tms_in,       // Synchronised mode select
  output reg  [15:0] state_out    // One-hot controller state
);
  localparam [15:0] S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SEL_DR = 16'h0004,
                    S_CAP_DR = 16'h0008, S_SH_DR = 16'h0010, S_EX1_DR = 16'h0020,
                    S_PA_DR = 16'h0040, S_EX2_DR = 16'h0080, S_UP_DR = 16'h0100,
                    S_SEL_IR = 16'h0200, S_CAP_IR = 16'h0400, S_SH_IR = 16'h0800,
                    S_EX1_IR = 16'h1000, S_PA_IR = 16'h2000, S_EX2_IR = 16'h4000,
                    S_UP_IR = 16'h8000;
  reg [15:0] state_d;

  // Next state per standard controller diagram
  always @* begin
    state_d = state_out;
    case (state_out)
      S_RESET:  state_d = tms_in ? S_RESET  : S_IDLE;
      S_IDLE:   state_d = tms_in ? S_SEL_DR : S_IDLE;
      S_SEL_DR: state_d = tms_in ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: state_d = tms_in ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  state_d = tms_in ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: state_d = tms_in ? S_UP_DR  : S_PA_DR;
      S_PA_DR:  state_d = tms_in ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: state_d = tms_in ? S_UP_DR  : S_SH_DR;
      S_UP_DR:  state_d = tms_in ? S_SEL_DR : S_IDLE;
      S_SEL_IR: state_d = tms_in ? S_RESET  : S_CAP_IR;
      S_CAP_IR: state_d = tms_in ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  state_d = tms_in ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: state_d = tms_in ? S_UP_IR  : S_PA_IR;
      S_PA_IR:  state_d = tms_in ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: state_d = tms_in ? S_UP_IR  : S_SH_IR;
      S_UP_IR:  state_d = tms_in ? S_SEL_DR : S_IDLE;
      default:  state_d = S_RESET;
    endcase
  end

  // Advance only on test clock rise
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_out <= S_RESET;
    end else if (tck_rise_in) begin
      state_out <= state_d;
    end
  end
endmodule // tap_state_ctrl
`default_nettype wire

// [verilog/sram_jtag_tap.v]
// Boundary-scan test access port of the synchronous memory
`timescale 1ns/10ps
`default_nettype none
`include "jtag_tap_defs.vh"
module sram_jtag_tap #(
  parameter [2:0]  REVISION  = 3'h0,          // Arbitrary revision value
  parameter [16:0] PART_CODE = 17'h0_0001,    // Arbitrary part code
  parameter [10:0] MAKER     = 11'h001        // Arbitrary maker code
) (
  input  wire         clock_in,         // System clock, 50 MHz
  input  wire         reset_n_in,       // Asynchronous reset, active low
  input  wire         tck_in,           // Test clock pin
  input  wire         tms_in,           // Test mode select pin
  input  wire         tdi_in,           // Test data in pin
  input  wire [107:0] pin_sample_in,    // Pin ring values for capture
  input  wire         mem_oe_in,        // Memory core wants to drive outputs
  output reg          tdo_out,          // Test data out
  output reg          tdo_oe_n_out,     // Test data out enable, low drives
  output wire         mem_oe_out,       // Final memory output driver enable
  output reg  [107:0] pin_drive_out,    // Boundary update values for pins
  output wire         ext_test_out      // External test drives pins
);
  // Controller states that the data path decodes
  localparam [15:0] S_RESET  = 16'h0001;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR  = 16'h0010;
  localparam [15:0] S_UP_DR  = 16'h0100;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR  = 16'h0800;
  localparam [15:0] S_UP_IR  = 16'h8000;

  // Synchronised test pins and detected test clock edges
  reg [`SYNC_STAGES-1:0] tck_sync_q;
  reg [`SYNC_STAGES-1:0] tms_sync_q;
  reg [`SYNC_STAGES-1:0] tdi_sync_q;
  reg                    tck_prev_q;
  wire                   tck_s = tck_sync_q[`SYNC_STAGES-1];
  wire                   tms_s = tms_sync_q[`SYNC_STAGES-1];
  wire                   tdi_s = tdi_sync_q[`SYNC_STAGES-1];
  wire                   tck_rise = tck_s & ~tck_prev_q;
  wire                   tck_fall = ~tck_s & tck_prev_q;
  wire [15:0]            state;

  // Instruction, data path and pin ring registers
  reg [`BSR_PINS-1:0]    pin_meta_q;
  reg [`BSR_PINS-1:0]    pin_sync_q;
  reg [`IR_WIDTH-1:0]    ir_shift_q;
  reg [`IR_WIDTH-1:0]    ir_q;
  reg                    bypass_q;
  reg [`ID_WIDTH-1:0]    id_shift_q;
  reg [`BSR_LEN-1:0]     bsr_shift_q;
  reg                    oe_cell_q;
  reg                    tdo_d;
  reg                    tdo_oe_n_d;
  wire [`ID_WIDTH-1:0]   id_word;

  // Two-stage synchronisers for test pins
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tck_sync_q <= {`SYNC_STAGES{1'b0}};
      tms_sync_q <= {`SYNC_STAGES{1'b1}};
      tdi_sync_q <= {`SYNC_STAGES{1'b1}};
      tck_prev_q <= 1'b0;
    end else begin
      tck_sync_q <= {tck_sync_q[`SYNC_STAGES-2:0], tck_in};
      tms_sync_q <= {tms_sync_q[`SYNC_STAGES-2:0], tms_in};
      tdi_sync_q <= {tdi_sync_q[`SYNC_STAGES-2:0], tdi_in};
      tck_prev_q <= tck_s;
    end
  end

  // Pin ring values pass two flip-flops before capture
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta_q <= {`BSR_PINS{1'b0}};
      pin_sync_q <= {`BSR_PINS{1'b0}};
    end else begin
      pin_meta_q <= pin_sample_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // State controller advances on detected test clock rises
  tap_state_ctrl u_ctrl (
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .tck_rise_in (tck_rise),
    .tms_in      (tms_s),
    .state_out   (state)
  );

  // Fixed identification word
  assign id_word[`ID_REV_MSB:`ID_REV_LSB]     = REVISION;
  assign id_word[`ID_PART_MSB:`ID_PART_LSB]   = PART_CODE;
  assign id_word[`ID_MAKER_MSB:`ID_MAKER_LSB] = MAKER;
  assign id_word[`ID_PRESENT_BIT]             = 1'b1;

  // Instruction shift and update, three bits
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_shift_q <= `IR_CAPTURE_VAL;
      ir_q       <= `IR_IDENT;
    end else if (tck_rise) begin
      if (state == S_RESET) begin
        ir_q <= `IR_IDENT;
      end else if (state == S_CAP_IR) begin
        ir_shift_q <= `IR_CAPTURE_VAL;
      end else if (state == S_SH_IR) begin
        ir_shift_q <= {tdi_s, ir_shift_q[`IR_WIDTH-1:1]};
      end else if (state == S_UP_IR) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // Path selection decoded from the active instruction
  wire sel_bsr = (ir_q == `IR_EXT_TEST) || (ir_q == `IR_SAMPLE_HIZ) ||
                 (ir_q == `IR_SAMPLE_PRE);
  wire sel_id  = (ir_q == `IR_IDENT);

  // Data registers: capture and shift
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bypass_q    <= 1'b0;
      id_shift_q  <= {`ID_WIDTH{1'b0}};
      bsr_shift_q <= {`BSR_LEN{1'b0}};
    end else if (tck_rise) begin
      if (state == S_CAP_DR) begin
        bypass_q <= 1'b0;
        if (sel_id) begin
          id_shift_q <= id_word;
        end
        if (sel_bsr) begin
          bsr_shift_q <= {oe_cell_q, pin_sync_q};
        end
      end else if (state == S_SH_DR) begin
        bypass_q <= tdi_s;
        if (sel_id) begin
          id_shift_q <= {tdi_s, id_shift_q[`ID_WIDTH-1:1]};
        end
        if (sel_bsr) begin
          bsr_shift_q <= {tdi_s, bsr_shift_q[`BSR_LEN-1:1]};
        end
      end
    end
  end

  // Enable cell latch; presets high at reset and in reset state
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oe_cell_q <= 1'b1;
    end else if (tck_rise) begin
      if (state == S_RESET) begin
        oe_cell_q <= 1'b1;
      end else if (state == S_UP_DR && sel_bsr) begin
        oe_cell_q <= bsr_shift_q[`BSR_OE_BIT];
      end
    end
  end

  // Pin update latches, loaded at update under boundary paths
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_drive_out <= {`BSR_PINS{1'b0}};
    end else if (tck_rise && state == S_UP_DR && sel_bsr) begin
      pin_drive_out <= bsr_shift_q[`BSR_PINS-1:0];
    end
  end

  // Output driver control per instruction
  assign ext_test_out = (ir_q == `IR_EXT_TEST);
  assign mem_oe_out   = (ir_q == `IR_SAMPLE_HIZ) ? 1'b0 :
                        ext_test_out ? oe_cell_q :
                        mem_oe_in;

  // Serial output mux, changes on test clock fall
  always @* begin
    tdo_d      = tdo_out;
    tdo_oe_n_d = tdo_oe_n_out;
    if (tck_fall) begin
      tdo_oe_n_d = 1'b1;
      tdo_d      = 1'b0;
      if (state == S_SH_IR) begin
        tdo_oe_n_d = 1'b0;
        tdo_d      = ir_shift_q[0];
      end else if (state == S_SH_DR) begin
        tdo_oe_n_d = 1'b0;
        if (sel_bsr) begin
          tdo_d = bsr_shift_q[0];
        end else if (sel_id) begin
          tdo_d = id_shift_q[0];
        end else begin
          tdo_d = bypass_q;
        end
      end
    end
  end

  // Register serial output and its enable
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tdo_out      <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end else begin
      tdo_out      <= tdo_d;
      tdo_oe_n_out <= tdo_oe_n_d;
    end
  end
endmodule // sram_jtag_tap
`default_nettype wire

// [tb/sram_jtag_tap_checker.sv]
// Port-level timing checks for the memory test access port
`timescale 1ns/10ps
`default_nettype none
module sram_jtag_tap_checker (
  input wire logic         clock_in,      // Clock
  input wire logic         reset_n_in,    // Reset
  input wire logic         tck_in,        // Test clock
  input wire logic         tms_in,        // Mode select
  input wire logic         tdi_in,        // Data in
  input wire logic [107:0] pin_sample_in, // Pin ring
  input wire logic         mem_oe_in,     // Core enable
  input wire logic         tdo_out,       // Data out
  input wire logic         tdo_oe_n_out,  // Data enable
  input wire logic         mem_oe_out,    // Final enable
  input wire logic [107:0] pin_drive_out, // Update values
  input wire logic         ext_test_out   // External test
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  // Port stays quiet for eight clocks after reset
  sequence s_quiet;
    (tdo_oe_n_out && !ext_test_out && pin_drive_out == 108'h0) [*8];
  endsequence
  property p_rst_quiet; $rose(reset_n_in) |-> s_quiet; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("port busy after reset");
  property p_rst_mem; $rose(reset_n_in) |-> mem_oe_out == mem_oe_in; endproperty
  a_rst_mem: assert property (p_rst_mem) else $error("enable disturbed");
  property p_hiz; !ext_test_out && mem_oe_out != mem_oe_in |-> !mem_oe_out; endproperty
  a_hiz: assert property (p_hiz) else $error("enable forced high");
  // Instruction and update values move only after a test clock rise
  property p_ir_hold;
    $changed({ext_test_out, pin_drive_out}) |-> $past(tck_in) && $past(tck_in, 2);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("update off rise");
  property p_oe_n; $changed(tdo_oe_n_out) |-> !$past(tck_in) && !$past(tck_in, 2); endproperty
  a_oe_n: assert property (p_oe_n) else $error("data enable off fall");
  property p_tdo_fall;
    !tdo_oe_n_out && !$past(tdo_oe_n_out) && $changed(tdo_out) |-> !$past(tck_in, 2);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("data out off fall");
  property p_tdo_idle; tdo_oe_n_out |-> !tdo_out; endproperty
  a_tdo_idle: assert property (p_tdo_idle) else $error("idle data out high");
  property p_oe_cell;
    ext_test_out && !$past(tck_in) && !$past(tck_in, 2) |-> $stable(mem_oe_out);
  endproperty
  a_oe_cell: assert property (p_oe_cell) else $error("enable not from cell");
endmodule // sram_jtag_tap_checker
`default_nettype wire

// [tb/jtag_ctrl_model.sv]
// Behavioural test controller that walks the port through its states
`timescale 1ns/10ps
`default_nettype none
module jtag_ctrl_model (
  input  wire logic clock_in,    // Bench clock
  input  wire logic tdo_in,      // Data from port
  input  wire logic tdo_oe_n_in, // Low while driven
  output var  logic tck_out,     // Low between frames
  output var  logic tms_out,     // Mode select
  output var  logic tdi_out      // Idles high
);
  logic bit_val; // Bit taken at last rise
  event bit_ev;  // Fires per driven bit
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // One 160 ns test clock; data taken just before the rise
  task automatic clk(input logic m, input logic d);
    tms_out = m;
    tdi_out = d;
    repeat (4) @(posedge clock_in);
    #1;
    if (tdo_oe_n_in === 1'b0) begin
      bit_val = tdo_in;
      -> bit_ev;
    end
    tck_out = 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    tck_out = 1'b0;
  endtask
  // Five highs reach the reset state, then settle in idle
  task automatic to_reset();
    repeat (5) clk(1'b1, 1'b1);
    clk(1'b0, 1'b1);
  endtask
  // From idle shift n bits, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] b);
    clk(1'b1, 1'b1);
    if (ir) clk(1'b1, 1'b1);
    clk(1'b0, 1'b1);
    clk(1'b0, 1'b1);
    for (int i = 0; i < n; i++) clk(i == n - 1, b[i]);
    clk(1'b1, 1'b1);
    clk(1'b0, 1'b1);
  endtask
endmodule // jtag_ctrl_model
`default_nettype wire

// [tb/tb_sram_jtag_tap.sv]
// Self-checking bench for the memory test access port
`timescale 1ns/10ps
`default_nettype none
module tb_sram_jtag_tap;
  localparam logic [31:0] ID_WORD = {3'h0, 17'h0_0a5c, 11'h2b3, 1'b1}; // Arbitrary values
  logic         clock_in, reset_n_in, tck, tms, tdi, mem_oe_in, tdo, tdo_oe_n, mem_oe, ext_test;
  logic [107:0] pin_sample, pin_drive;
  logic [127:0] b;
  logic [31:0]  r;
  logic [31:0]  seed = 32'h5841_c7d7;
  logic         bnd;
  logic         oe_cell = 1'b1;
  logic         expq[$];
  int           n_mismatch = 0;
  int           n_compared = 0;
  sram_jtag_tap #(.REVISION(3'h0), .PART_CODE(17'h0_0a5c), .MAKER(11'h2b3)) uut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .pin_sample_in(pin_sample), .mem_oe_in(mem_oe_in), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
    .mem_oe_out(mem_oe), .pin_drive_out(pin_drive), .ext_test_out(ext_test));
  jtag_ctrl_model drv (.clock_in(clock_in), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n),
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  always #10 clock_in = ~clock_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [107:0] e, input logic [107:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Note captured bits then random fill, shift them, expect all consumed
  task automatic path(input logic ir, input int len, input logic [108:0] cap,
                      input logic [2:0] code);
    b = {rnd(), rnd(), rnd(), rnd()};
    if (ir) b[10:8] = code;
    for (int i = 0; i < len + 8; i++) expq.push_back(i < len ? cap[i] : b[i - len]);
    drv.scan(ir, len + 8, b);
    chk("bits left", 108'h0, 108'(expq.size()));
    expq.delete();
  endtask
  // Each driven bit is matched with the oldest note
  always @(drv.bit_ev) begin
    if (expq.size() == 0) chk("extra bit", 108'h0, 108'h1);
    else chk("tdo", {107'h0, expq.pop_front()}, {107'h0, drv.bit_val});
  end
  initial begin
    repeat (60000) @(posedge clock_in);
    n_mismatch++;
    results();
  end
  initial begin
    clock_in = 1'b0;
    reset_n_in = 1'b0;
    mem_oe_in = 1'b1;
    pin_sample = 108'h0;
    repeat (16) @(posedge clock_in);
    #1;
    reset_n_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    drv.to_reset();
    chk("ext test", 108'h0, {107'h0, ext_test});
    path(1'b0, 32, 109'(ID_WORD), 3'h0);
    $display("test ident done");
    for (int c = 0; c < 8; c++) begin
      if (c == 3 || c == 5 || c == 6) continue;
      bnd = (c == 0 || c == 2 || c == 4);
      path(1'b1, 3, 109'h1, c[2:0]);
      r = rnd();
      mem_oe_in = r[0];
      pin_sample = 108'({rnd(), rnd(), rnd(), rnd()});
      @(posedge clock_in);
      #1;
      chk("ext test", {107'h0, c == 0}, {107'h0, ext_test});
      chk("mem oe", {107'h0, c == 2 ? 1'b0 : c == 0 ? oe_cell : mem_oe_in}, {107'h0, mem_oe});
      path(1'b0, bnd ? 109 : c == 1 ? 32 : 1,
           bnd ? {oe_cell, pin_sample} : c == 1 ? 109'(ID_WORD) : 109'h0, 3'h0);
      if (bnd) begin
        oe_cell = b[116];
        chk("pin drive", b[115:8], pin_drive);
      end
      if (c == 0) chk("oe cell", {107'h0, oe_cell}, {107'h0, mem_oe});
      $display("test code %0d done", c);
    end
    drv.to_reset();
    path(1'b0, 32, 109'(ID_WORD), 3'h0);
    $display("test reset return done");
    results();
  end
endmodule // tb_sram_jtag_tap
bind sram_jtag_tap sram_jtag_tap_checker chk_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
  .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in), .pin_sample_in(pin_sample_in),
  .mem_oe_in(mem_oe_in), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out),
  .mem_oe_out(mem_oe_out), .pin_drive_out(pin_drive_out), .ext_test_out(ext_test_out));
`default_nettype wire
